// >>> fetch_decode_pkg.sv
`default_nettype none
package fetch_decode_pkg;
  // Program counter width in byte-address bits
  localparam int PC_W = 21;
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  // Absolute target field width (word address)
  localparam int ABS_W = 20;
  // Relative branch offset width (words)
  localparam int REL_W = 11;
  // Trailing-word marker and literal field
  localparam logic [3:0] TRAIL_MARK = 4'hf;
  localparam int LIT_W = 12;
  // First-word opcode patterns (top bits)
  localparam logic [7:0] OP_CALL0 = 8'hec;
  localparam logic [7:0] OP_CALL1 = 8'hed;
  localparam logic [7:0] OP_JUMP0 = 8'hee;
  localparam logic [7:0] OP_JUMP1 = 8'hef;
  localparam logic [3:0] OP_FFMOVE = 4'hc;
  localparam logic [9:0] OP_PTRLOAD = 10'h3b8;
  localparam logic [15:0] OP_LFFMOVE_HI = 16'h0060;
  localparam logic [15:0] OP_LIFMOVE_HI = 16'h0062;
  localparam logic [4:0] OP_BRA = 5'h1a;
  localparam logic [15:0] OPC_NOP = 16'h0000;

  typedef enum logic [1:0] {
    IK_SINGLE,
    IK_TWO,
    IK_THREE
  } instr_kind_t;

  // Word issued to the execute stage
  typedef struct packed {
    logic             valid;
    logic             is_nop;
    logic             is_operand;
    logic [1:0]       operand_idx;
    logic [LIT_W-1:0] literal;
    logic [15:0]      opcode;
    logic [PC_W-1:0]  pc;
  } issue_t;
endpackage
`default_nettype wire

// >>> instruction_fetch_multiword_decode.sv
`default_nettype none

// Limitations and intent:
// A skip request rides with the word it is sampled with and turns the
// very next consumed word into a no-op unless that word is an in-sequence tail, which drops the request; when that word is a head, its
// tails need no extra tracking because their 1111 marker alone already
// makes them no-ops once the sequencer stays idle.
// Call and absolute jump share one target path; the return address of
// a call is left to the execute stage, which sees the head's counter.
// Trailing words never move the counter off its sequential path except
// for the absolute target, which lands together with the last tail.
// Only one instruction is decoded per consumed word, so a stalled fetch
// port (no valid word) freezes both the counter and the sequencer.
module instruction_fetch_multiword_decode (
  input  wire logic                              ref_clk,
  input  wire logic                              rst_n,
  input  wire logic [15:0]                       prog_word,
  input  wire logic                              prog_valid,
  input  wire logic                              skip_next,
  output logic [fetch_decode_pkg::PC_W-1:0]      prog_addr,
  output fetch_decode_pkg::issue_t               issue
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_OPERAND
  } seq_state_t;

  seq_state_t                            state_reg, state_next;
  logic [1:0]                            left_reg, left_next;
  logic [1:0]                            idx_reg, idx_next;
  logic                                  skip_reg, skip_next_v;
  logic [fetch_decode_pkg::PC_W-1:0]     pc_reg, pc_next;
  fetch_decode_pkg::issue_t              issue_reg, issue_next;

  logic                                  trail_word;
  logic [fetch_decode_pkg::PC_W-1:0]     pc_inc;
  logic [fetch_decode_pkg::PC_W-1:0]     rel_disp;
  fetch_decode_pkg::instr_kind_t         kind;

  // Named recognisers, so the classifier and the branch step share them
  logic                                  is_call;
  logic                                  is_jump;
  logic                                  is_ffmove;
  logic                                  is_ptrload;
  logic                                  is_lffmove;
  logic                                  is_lifmove;
  logic                                  is_branch;
  logic                                  head_abs;

  // Two-word heads, decoded from the fetch port
  assign is_call    = (prog_word[15:8] == fetch_decode_pkg::OP_CALL0) ||
                      (prog_word[15:8] == fetch_decode_pkg::OP_CALL1);
  assign is_jump    = (prog_word[15:8] == fetch_decode_pkg::OP_JUMP0) ||
                      (prog_word[15:8] == fetch_decode_pkg::OP_JUMP1);
  assign is_ffmove  = (prog_word[15:12] == fetch_decode_pkg::OP_FFMOVE);
  assign is_ptrload = (prog_word[15:6] == fetch_decode_pkg::OP_PTRLOAD);
  // Three-word heads match the whole word; a near miss stays single
  assign is_lffmove = (prog_word == fetch_decode_pkg::OP_LFFMOVE_HI);
  assign is_lifmove = (prog_word == fetch_decode_pkg::OP_LIFMOVE_HI);
  // Relative branch family
  assign is_branch  = (prog_word[15:11] == fetch_decode_pkg::OP_BRA);

  // Absolute head held in the issue register; the target needs its low
  // address byte, which the fetch port no longer shows at the tail
  assign head_abs = (issue_reg.opcode[15:8] == fetch_decode_pkg::OP_JUMP0) ||
                    (issue_reg.opcode[15:8] == fetch_decode_pkg::OP_JUMP1) ||
                    (issue_reg.opcode[15:8] == fetch_decode_pkg::OP_CALL0) ||
                    (issue_reg.opcode[15:8] == fetch_decode_pkg::OP_CALL1);

  // Head classification; a two-word match wins over a three-word one
  always_comb begin
    kind = fetch_decode_pkg::IK_SINGLE;
    if (is_call || is_jump || is_ffmove || is_ptrload) begin
      kind = fetch_decode_pkg::IK_TWO;
    end else if (is_lffmove || is_lifmove) begin
      kind = fetch_decode_pkg::IK_THREE;
    end
  end

  assign trail_word = (prog_word[15:12] == fetch_decode_pkg::TRAIL_MARK);
  assign pc_inc     = pc_reg + fetch_decode_pkg::PC_STEP;
  // Word offset sign-extended then doubled into bytes
  assign rel_disp   = {{(fetch_decode_pkg::PC_W-fetch_decode_pkg::REL_W-1)
                        {prog_word[fetch_decode_pkg::REL_W-1]}},
                       prog_word[fetch_decode_pkg::REL_W-1:0], 1'b0};

  // Sequencer and fetch pointer next state
  always_comb begin
    state_next  = state_reg;
    left_next   = left_reg;
    idx_next    = idx_reg;
    skip_next_v = skip_reg;
    pc_next     = pc_reg;
    issue_next  = issue_reg;
    issue_next.valid = 1'b0;
    if (prog_valid) begin
      pc_next = pc_inc;
      issue_next.valid       = 1'b1;
      issue_next.pc          = pc_reg;
      issue_next.opcode      = prog_word;
      issue_next.literal     = prog_word[fetch_decode_pkg::LIT_W-1:0];
      issue_next.is_nop      = 1'b0;
      issue_next.is_operand  = 1'b0;
      issue_next.operand_idx = 2'h0;
      skip_next_v            = skip_next;
      case (state_reg)
        ST_OPERAND: begin
          // Trailing word arriving in sequence feeds the head
          issue_next.is_operand  = 1'b1;
          issue_next.operand_idx = idx_reg;
          idx_next  = idx_reg + 2'h1;
          left_next = left_reg - 2'h1;
          if (left_reg == 2'h1) begin
            state_next = ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (skip_reg || trail_word) begin
            // Skipped word or orphan trailing word becomes a no-op
            issue_next.is_nop = 1'b1;
            issue_next.opcode = fetch_decode_pkg::OPC_NOP;
            if (skip_reg && kind != fetch_decode_pkg::IK_SINGLE) begin
              skip_next_v = 1'b0; // tails of skipped head also no-op via marker
            end
          end else begin
            idx_next = 2'h1;
            if (kind == fetch_decode_pkg::IK_TWO) begin
              state_next = ST_OPERAND;
              left_next  = 2'h1;
            end else if (kind == fetch_decode_pkg::IK_THREE) begin
              state_next = ST_OPERAND;
              left_next  = 2'h2;
            end
            // Branch target replaces the sequential step
            if (is_branch) begin
              pc_next = pc_inc + rel_disp;
            end
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
      // Absolute jump completes once its trailing word arrives
      // Held head must still be the head itself, not an earlier tail
      if (state_reg == ST_OPERAND && left_reg == 2'h1 && head_abs &&
          issue_reg.is_operand == 1'b0) begin
        pc_next = {prog_word[fetch_decode_pkg::LIT_W-1:0],
                   issue_reg.opcode[7:0], 1'b0};
      end
    end
  end

  // Sequencer registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      left_reg  <= 2'h0;
      idx_reg   <= 2'h0;
      skip_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      left_reg  <= left_next;
      idx_reg   <= idx_next;
      skip_reg  <= skip_next_v;
    end
  end

  // Fetch pointer; bit zero forced low so no path can leave it odd
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_reg <= fetch_decode_pkg::PC_RESET;
    end else begin
      pc_reg <= {pc_next[fetch_decode_pkg::PC_W-1:1], 1'b0};
    end
  end

  // Issue register; an all-zero image reads as nothing issued
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      issue_reg <= '0;
    end else begin
      issue_reg <= issue_next;
    end
  end

  // Outputs straight from their registers
  assign prog_addr = pc_reg;
  assign issue     = issue_reg;

endmodule
`default_nettype wire

// >>> fetch_decode_chk_sva.sv
`default_nettype none
module fetch_decode_chk (
  input wire logic                     ref_clk,
  input wire logic                     rst_n,
  input wire logic [15:0]              prog_word,
  input wire logic                     prog_valid,
  input wire logic                     skip_next,
  input wire logic [20:0]              prog_addr,
  input wire fetch_decode_pkg::issue_t issue
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Tail and branch words as the fetch port takes them
  wire logic tr = prog_valid && prog_word[15:12] == 4'hf;
  wire logic br = prog_valid && prog_word[15:11] == 5'h1a;
  // Skip request carried to the next consumed word
  logic skp;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) skp <= 1'b0;
    else if (prog_valid) skp <= skip_next;
  end
  sequence jmp_s; prog_valid && !skp && prog_word[15:8] == 8'hef ##1 tr; endsequence
  sequence two_s; prog_valid && !skp && prog_word[15:12] == 4'hc ##1 tr; endsequence
  sequence three_s; prog_valid && !skp && prog_word == 16'h0060 ##1 tr ##1 tr; endsequence
  sequence stray_s; br ##1 tr; endsequence
  AST_EVEN: assert property (prog_addr[0] == 1'b0) else $error("odd fetch address");
  AST_HOLD: assert property (!prog_valid |=> $stable(prog_addr)) else $error("idle move");
  AST_STEP: assert property (prog_valid && !tr && !br |=> prog_addr == $past(prog_addr) + 21'h2)
    else $error("counter did not step by two");
  AST_ISSUE: assert property (prog_valid |=> issue.valid && issue.pc == $past(prog_addr))
    else $error("word not issued");
  AST_BRA: assert property (br |=> prog_addr == $past(prog_addr) + 21'h2 +
    {{9{$past(prog_word[10])}}, $past(prog_word[10:0]), 1'b0}) else $error("bad branch target");
  AST_JMP: assert property (jmp_s |=>
    prog_addr == {$past(prog_word[11:0]), $past(prog_word[7:0], 2), 1'b0}) else $error("bad jump");
  AST_TWO: assert property (two_s |=> issue.is_operand && issue.operand_idx == 2'h1 &&
    issue.literal == $past(prog_word[11:0])) else $error("two-word operand lost");
  AST_THREE: assert property (three_s |=> issue.is_operand && issue.operand_idx == 2'h2 &&
    issue.literal == $past(prog_word[11:0])) else $error("three-word operand lost");
  AST_NOP: assert property (stray_s |=> issue.is_nop && issue.opcode == 16'h0000)
    else $error("lone tail not a no-op");
endmodule
`default_nettype wire

// >>> prog_mem_model.sv
`default_nettype none
module prog_mem_model (
  input  wire logic [20:0] prog_addr,
  output logic      [15:0] prog_word
);
  // Jump, moves with 1111-topped tails, branch back onto a lone tail
  localparam logic [15:0] IMG [9] = '{16'hef03, 16'hf000, 16'hf123, 16'hc123, 16'hf456,
    16'h0060, 16'hf48c, 16'hf456, 16'hd7f9};
  // Byte address, bit zero ignored; unused space shifts with the address
  assign prog_word = prog_addr < 21'h12 ? IMG[prog_addr[4:1]] : ~prog_addr[15:0];
endmodule
`default_nettype wire

// >>> tb_instruction_fetch_multiword_decode.sv
`default_nettype none
module tb_instruction_fetch_multiword_decode;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     ref_clk = 1'b0;
  logic                     rst_n = 1'b0;
  logic                     prog_valid = 1'b0;
  logic                     skip_req = 1'b0;
  wire logic [15:0]         prog_word;
  logic [20:0]              prog_addr;
  fetch_decode_pkg::issue_t issue;
  int                       mismatches = 0;
  int                       n_compared = 0;
  int                       cycles = 0;
  // Expected issues: kind (0 head, 1/2 tail, 4 no-op), pc, opcode or literal
  localparam logic [43:0] EXP [9] = '{44'h0000000ef03, 44'h10000020000, 44'h0000006c123,
    44'h10000080456, 44'h000000a0060, 44'h100000c048c, 44'h200000e0456, 44'h0000010d7f9,
    44'h40000040000};
  prog_mem_model i_mem (.prog_addr(prog_addr), .prog_word(prog_word));
  // Skip input driven by the skip scenario
  instruction_fetch_multiword_decode i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .prog_word(prog_word), .prog_valid(prog_valid), .skip_next(skip_req),
    .prog_addr(prog_addr), .issue(issue));
  initial forever #12.5 ref_clk = ~ref_clk;
  task automatic stop_test();
    if (mismatches == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic ok, input string what);
    n_compared++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask
  // Back-to-back run through the whole image
  task automatic run_image();
    logic [43:0] e;
    prog_valid = 1'b1;
    for (int i = 0; i < 9; i++) begin
      e = EXP[i];
      @(posedge ref_clk);
      #1;
      check(issue.valid === 1'b1 && issue.pc === e[36:16], "pc");
      case (e[43:40])
        4'h0: check(issue.opcode === e[15:0] && issue.is_nop === 1'b0, "head");
        4'h4: check(issue.is_nop === 1'b1 && issue.opcode === 16'h0000, "no-op");
        default: check(issue.literal === e[11:0], "tail");
      endcase
    end
  endtask
  // Fetch gap: counter holds, nothing issues, then one step of two
  task automatic hold_idle();
    logic [20:0] a;
    prog_valid = 1'b0;
    a = prog_addr;
    repeat (3) @(posedge ref_clk);
    #1;
    check(a === 21'h6 && prog_addr === a && issue.valid === 1'b0, "idle");
    prog_valid = 1'b1;
    @(posedge ref_clk);
    #1;
    check(issue.pc === a && prog_addr === a + 21'h2, "resume");
  endtask
  // Skip on the tail at 8: the three-word head and both tails become no-ops
  task automatic skip_head();
    skip_req = 1'b1;
    @(posedge ref_clk);
    #1;
    skip_req = 1'b0;
    check(issue.is_operand === 1'b1 && issue.pc === 21'h8, "tail before skip");
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      #1;
      check(issue.is_nop === 1'b1 && issue.pc === 21'ha + 21'(2 * i), "skipped");
    end
  endtask
  // Ceiling far above the few dozen cycles needed
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      stop_test();
    end
  end
  // Reset, then the scenarios
  initial begin
    repeat (20) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    run_image();
    hold_idle();
    skip_head();
    stop_test();
  end
endmodule
bind instruction_fetch_multiword_decode fetch_decode_chk i_chk (.ref_clk(ref_clk),
  .rst_n(rst_n), .prog_word(prog_word), .prog_valid(prog_valid), .skip_next(skip_next),
  .prog_addr(prog_addr), .issue(issue));
`default_nettype wire
